// ===== src/sdf_filter.sv
module sdf_filter
    import sdf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Configuration
    input wire logic [SDF_SEL_W-1:0] decimation_ratio_select_i,
    // Modulator side
    input wire logic mod_bit_i,
    output logic modulator_rate_o,
    // Sample output
    output sdf_sample_s sample_o,
    output logic sample_valid_n_o
);

    // ========================================
    // Ratio decode
    logic [3:0] ratio_log2;
    logic [3:0] s3_log2;
    logic [SDF_POST_LOG2_W-1:0] post_log2;
    logic [3:0] s3_diff;
    logic [5:0] s3_shift;
    logic [4:0] fast_shift;
    logic [SDF_CNT_W-1:0] ratio_mask;
    logic [9:0] s3_mask;

    always_comb begin
        ratio_log2 = SDF_MIN_RATIO_LOG2 + {1'b0, decimation_ratio_select_i};
        // Sinc3 decimation saturates at 1024, post stage takes the rest
        s3_log2 = (ratio_log2 > SDF_SINC3_MAX_LOG2) ? SDF_SINC3_MAX_LOG2 : ratio_log2;
        post_log2 = SDF_POST_LOG2_W'(ratio_log2 - s3_log2);
        s3_diff = SDF_SINC3_MAX_LOG2 - s3_log2;
        s3_shift = {2'b00, s3_diff} * 6'h03;
        fast_shift = SDF_FULL_SCALE_LOG2 - {1'b0, ratio_log2};
        ratio_mask = SDF_CNT_W'((15'h0001 << ratio_log2) - 15'h0001);
        s3_mask = 10'((11'h001 << s3_log2) - 11'h001);
    end

    // ========================================
    // Modulator tick, half the main clock
    logic mod_phase;
    logic next_mod_phase;
    logic mod_tick;

    always_comb begin
        next_mod_phase = ~mod_phase;
        mod_tick = mod_phase;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mod_phase <= 1'b0;
            modulator_rate_o <= 1'b0;
        end else begin
            mod_phase <= next_mod_phase;
            modulator_rate_o <= next_mod_phase;
        end
    end

    // ========================================
    // Output period counter
    logic [SDF_CNT_W-1:0] period_cnt;
    logic [SDF_CNT_W-1:0] next_period_cnt;
    logic period_last;
    logic s3_dump;

    always_comb begin
        period_last = mod_tick && ((period_cnt & ratio_mask) == ratio_mask);
        s3_dump = mod_tick && ((period_cnt[9:0] & s3_mask) == s3_mask);
        next_period_cnt = period_cnt;
        if (mod_tick) begin
            next_period_cnt = (period_cnt + 14'h0001) & ratio_mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            period_cnt <= '0;
        end else begin
            period_cnt <= next_period_cnt;
        end
    end

    // ========================================
    // Fast-settling path: first-order average over one full period
    logic [SDF_ONES_W-1:0] ones;
    logic [SDF_ONES_W-1:0] next_ones;
    logic [SDF_ONES_W-1:0] fast_sum;
    logic [SDF_OUT_W-1:0] fast_hold;
    logic [SDF_OUT_W-1:0] next_fast_hold;

    always_comb begin
        fast_sum = ones + {{(SDF_ONES_W-1){1'b0}}, mod_bit_i};
        next_ones = ones;
        next_fast_hold = fast_hold;
        if (period_last) begin
            // Settled after a single data period
            next_fast_hold = {{(SDF_OUT_W-SDF_ONES_W){1'b0}}, fast_sum} << fast_shift;
            next_ones = '0;
        end else if (mod_tick) begin
            next_ones = fast_sum;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ones <= '0;
            fast_hold <= '0;
        end else begin
            ones <= next_ones;
            fast_hold <= next_fast_hold;
        end
    end

    // ========================================
    // Sinc3 path: three integrators, three combs at the decimated rate
    logic [SDF_ACC_W-1:0] integ [3];
    logic [SDF_ACC_W-1:0] next_integ [3];
    logic [SDF_ACC_W-1:0] dly [3];
    logic [SDF_ACC_W-1:0] next_dly [3];
    logic [SDF_ACC_W-1:0] comb_in [4];
    logic [SDF_OUT_W-1:0] s3_norm;

    always_comb begin
        next_integ = integ;
        next_dly = dly;
        if (mod_tick) begin
            next_integ[0] = integ[0] + {{(SDF_ACC_W-1){1'b0}}, mod_bit_i};
            next_integ[1] = integ[1] + integ[0];
            next_integ[2] = integ[2] + integ[1];
        end
        // Wrapping arithmetic is exact as long as the result fits the width
        comb_in[0] = integ[2];
        for (int k = 0; k < 3; k++) begin
            comb_in[k+1] = comb_in[k] - dly[k];
        end
        if (s3_dump) begin
            for (int k = 0; k < 3; k++) begin
                next_dly[k] = comb_in[k];
            end
        end
        // Full scale of every ratio lands on the same 2^30 grid
        s3_norm = comb_in[3][SDF_OUT_W-1:0] << s3_shift;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int k = 0; k < 3; k++) begin
                integ[k] <= '0;
                dly[k] <= '0;
            end
        end else begin
            integ <= next_integ;
            dly <= next_dly;
        end
    end

    // ========================================
    // First-order post stage
    logic post_valid;
    logic [SDF_OUT_W-1:0] post_value;

    sdf_post_avg u_post (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(s3_dump),
        .group_last_i(period_last),
        .group_log2_i(post_log2),
        .in_value_i(s3_norm),
        .out_valid_o(post_valid),
        .out_value_o(post_value)
    );

    // ========================================
    // Path selection and output register
    sdf_path_e path;
    sdf_path_e next_path;
    sdf_sample_s next_sample;
    logic next_valid_n;

    always_comb begin
        next_path = path;
        next_sample = sample_o;
        next_valid_n = 1'b1;
        // Every result is delivered, settled or not
        if (post_valid) begin
            next_valid_n = 1'b0;
            case (path)
                SDF_ST_FAST1: begin
                    next_sample = '{from_fast: 1'b1, value: fast_hold};
                    next_path = SDF_ST_FAST2;
                end
                SDF_ST_FAST2: begin
                    next_sample = '{from_fast: 1'b1, value: fast_hold};
                    next_path = SDF_ST_SINC3;
                end
                SDF_ST_SINC3: begin
                    next_sample = '{from_fast: 1'b0, value: post_value};
                    next_path = SDF_ST_SINC3;
                end
                default: begin
                    next_sample = '{from_fast: 1'b1, value: fast_hold};
                    next_path = SDF_ST_FAST1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            path <= SDF_ST_FAST1;
            sample_o <= '0;
            sample_valid_n_o <= 1'b1;
        end else begin
            path <= next_path;
            sample_o <= next_sample;
            sample_valid_n_o <= next_valid_n;
        end
    end

endmodule : sdf_filter

// ===== src/sdf_pkg.sv
// What this block does
// - One output sample per ratio modulator periods; output rate is modulator rate over ratio.
// - Three-bit select picks ratio 128 to 16384, powers of two, eight rates.
// - Modulator bit feeds the sinc3 path and the fast path at once.
// - After reset the output is taken from the fast first-order path.
// - After exactly two fast outputs switch to sinc3 path until next reset.
// - Ratios 128 to 1024 pass the sinc3 result straight out, post stage averages groups of one.
// - Ratios 2048 up run sinc3 at 1024, post stage decimates by 2 to 16.
// - Filtering is plain averaging, a linear-phase FIR low-pass structure.
// - Unsettled samples are delivered like any other, never gated or flagged.
// - Settling times 432,816,1584,3120,6192,10288,18480,34864 modulator periods.
// - Modulator rate runs at half the main clock.
// - Fast path settles in one data period, sinc3 path in three.
package sdf_pkg;

    // ========================================
    // Widths and ratio encoding
    localparam int SDF_SEL_W = 3;
    localparam int SDF_ACC_W = 32;
    localparam int SDF_OUT_W = 31;
    localparam int SDF_CNT_W = 14;
    localparam int SDF_ONES_W = 15;
    localparam int SDF_POST_LOG2_W = 3;
    localparam int SDF_POST_EXTRA_W = 4;
    localparam logic [3:0] SDF_MIN_RATIO_LOG2 = 4'h7;
    localparam logic [3:0] SDF_SINC3_MAX_LOG2 = 4'ha;
    localparam logic [4:0] SDF_FULL_SCALE_LOG2 = 5'h1e;

    // ========================================
    // Settling times per select code, modulator periods
    localparam int SDF_SETTLE_TMOD [8] = '{432, 816, 1584, 3120, 6192, 10288, 18480, 34864};

    // ========================================
    // Output path sequencing
    typedef enum logic [2:0] {
        SDF_ST_FAST1 = 3'b001,
        SDF_ST_FAST2 = 3'b010,
        SDF_ST_SINC3 = 3'b100
    } sdf_path_e;

    typedef struct packed {
        logic from_fast;
        logic [SDF_OUT_W-1:0] value;
    } sdf_sample_s;

endpackage : sdf_pkg

// ===== src/sdf_post_avg.sv
module sdf_post_avg
    import sdf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Sinc3 results in
    input wire logic in_valid_i,
    input wire logic group_last_i,
    input wire logic [SDF_POST_LOG2_W-1:0] group_log2_i,
    input wire logic [SDF_OUT_W-1:0] in_value_i,
    // Averaged results out
    output logic out_valid_o,
    output logic [SDF_OUT_W-1:0] out_value_o
);

    localparam int SUM_W = SDF_OUT_W + SDF_POST_EXTRA_W;

    logic [SUM_W-1:0] acc;
    logic [SUM_W-1:0] next_acc;
    logic next_out_valid;
    logic [SDF_OUT_W-1:0] next_out_value;
    logic [SUM_W-1:0] sum;

    // ========================================
    // Group accumulation
    always_comb begin
        sum = acc + {{SDF_POST_EXTRA_W{1'b0}}, in_value_i};
        next_acc = acc;
        next_out_valid = 1'b0;
        next_out_value = out_value_o;
        if (in_valid_i) begin
            if (group_last_i) begin
                // A group of one is a plain pass-through
                next_out_value = SDF_OUT_W'(sum >> group_log2_i);
                next_out_valid = 1'b1;
                next_acc = '0;
            end else begin
                next_acc = sum;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc <= '0;
            out_valid_o <= 1'b0;
            out_value_o <= '0;
        end else begin
            acc <= next_acc;
            out_valid_o <= next_out_valid;
            out_value_o <= next_out_value;
        end
    end

endmodule : sdf_post_avg

// ===== testbench/sdf_monitor.sv
module sdf_monitor
    import sdf_pkg::*;
(
    // Watched ports
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [SDF_SEL_W-1:0] decimation_ratio_select_i,
    input wire logic mod_bit_i,
    input wire logic modulator_rate_o,
    input wire sdf_sample_s sample_o,
    input wire logic sample_valid_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Cycles since release or last strobe, strobe count
    logic [15:0] gap;
    logic [15:0] next_gap;
    logic [1:0] nstb;
    logic [1:0] next_nstb;
    wire logic strobe = !sample_valid_n_o;
    wire logic [15:0] two_n = 16'h0100 << decimation_ratio_select_i;

    always_comb begin
        next_gap = strobe ? 16'h0001 : gap + 16'h0001;
        next_nstb = (strobe && nstb != 2'h3) ? nstb + 2'h1 : nstb;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gap <= 16'h0000;
            nstb <= 2'h0;
        end else begin
            gap <= next_gap;
            nstb <= next_nstb;
        end
    end

    // ========================================
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_strobe_pulse;
        !sample_valid_n_o ##1 sample_valid_n_o;
    endsequence

    a_rate_half: assert property (!$past(reset_i) |->
        modulator_rate_o != $past(modulator_rate_o))
        else $error("modulator rate did not toggle");
    a_strobe_single: assert property ($fell(sample_valid_n_o) |-> s_strobe_pulse)
        else $error("strobe not one cycle");
    a_first_period: assert property (strobe && nstb == 2'h0 |-> gap == two_n + 16'h0001)
        else $error("first strobe at wrong cycle");
    a_period_gap: assert property (strobe && nstb != 2'h0 |-> gap == two_n)
        else $error("strobe spacing wrong");
    a_no_early: assert property (nstb == 2'h0 && gap <= two_n |-> sample_valid_n_o)
        else $error("strobe before first period ends");
    a_fast_first: assert property (strobe && !nstb[1] |-> sample_o.from_fast)
        else $error("first samples not from fast path");
    a_sinc_after: assert property (strobe && nstb[1] |-> !sample_o.from_fast)
        else $error("third sample onward not from sinc path");
    a_hold_value: assert property (!$stable(sample_o) |-> strobe)
        else $error("sample changed without strobe");
    a_value_range: assert property (strobe |-> sample_o.value <= 31'h40000000)
        else $error("sample above full scale");
endmodule : sdf_monitor

bind sdf_filter sdf_monitor u_mon (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .decimation_ratio_select_i(decimation_ratio_select_i),
    .mod_bit_i(mod_bit_i),
    .modulator_rate_o(modulator_rate_o),
    .sample_o(sample_o),
    .sample_valid_n_o(sample_valid_n_o)
);

// ===== testbench/sdf_mod_model.sv
module sdf_mod_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Modulator side
    input wire logic modulator_rate_i,
    input wire logic [2:0] level_i,
    output logic mod_bit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Periodic stream of density level/4, new bit per modulator tick
    logic [1:0] idx;
    logic [1:0] next_idx;

    always_comb begin
        next_idx = modulator_rate_i ? idx + 2'h1 : idx;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            idx <= 2'h0;
        end else begin
            idx <= next_idx;
        end
    end

    assign mod_bit_o = {1'b0, idx} < level_i;
endmodule : sdf_mod_model

// ===== testbench/sdf_filter_tb.sv
module sdf_filter_tb
    import sdf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {sdf_sample_s s; logic chk; int cyc;} sdf_exp_s;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [2:0] level = 3'h0;
    logic mod_bit;
    logic rate;
    sdf_sample_s sample;
    logic valid_n;
    sdf_exp_s exp_q[$];
    sdf_exp_s e_w;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    sdf_filter u_dut (.clk_i(clk_i), .reset_i(reset_i), .decimation_ratio_select_i(sel),
        .mod_bit_i(mod_bit), .modulator_rate_o(rate), .sample_o(sample),
        .sample_valid_n_o(valid_n));
    sdf_mod_model u_mod (.clk_i(clk_i), .reset_i(reset_i), .modulator_rate_i(rate),
        .level_i(level), .mod_bit_o(mod_bit));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ========================================
    // Checking
    task automatic cmp_sample(input string what, input logic [31:0] ev, input logic [31:0] gv);
        cmp_count++;
        if (gv !== ev) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, ev, gv);
        end
    endtask : cmp_sample

    task automatic cmp_cycle(input int ev, input int gv);
        cmp_count++;
        if (gv != ev) begin
            n_mismatch++;
            $display("Error strobe cycle expected %0d seen %0d", ev, gv);
        end
    endtask : cmp_cycle

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_i) begin
        if (reset_i) cyc <= 0;
        else cyc <= cyc + 1;
        if (!reset_i && valid_n !== 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("Error strobe expected none seen %0d", cyc);
            end else begin
                e_w = exp_q.pop_front();
                cmp_cycle(e_w.cyc, cyc);
                if (e_w.chk) cmp_sample("sample", e_w.s, sample);
                else cmp_sample("path", 32'(e_w.s.from_fast), 32'(sample.from_fast));
            end
        end
    end

    // ========================================
    // Stimulus
    task automatic run(input logic [2:0] s, input int n);
        int lv;
        int nn;
        int t;
        sdf_exp_s e;
        lv = $urandom % 5;
        nn = 128 << s;
        @(posedge clk_i);
        reset_i <= 1'b1;
        sel <= s;
        level <= 3'(lv);
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int k = 1; k <= n; k++) begin
            e.s.from_fast = (k <= 2);
            e.s.value = 31'(lv) << 28;
            e.chk = (k <= 2) || (k * nn > SDF_SETTLE_TMOD[s]);
            e.cyc = 2 * nn * k + 1;
            exp_q.push_back(e);
        end
        t = 0;
        while (exp_q.size() != 0 && t < 40000) begin
            @(posedge clk_i);
            t++;
        end
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("Error pending samples expected 0 seen %0d", exp_q.size());
            exp_q.delete();
        end
    endtask : run

    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        $display("Error watchdog expected finish seen timeout");
        end_sim();
    end

    initial begin
        void'($urandom(23));
        for (int c = 0; c < 8; c++) run(3'(c), 1);
        run(3'h0, 6);
        run(3'h4, 5);
        end_sim();
    end
endmodule : sdf_filter_tb
